// ### verilog/spfd_top.sv
// Segment profile field decoder with sequencer and register file
//
// Behaviour
// - interrupt bit of following segment, judged at trigger
// - overlap field 0 off, 1 on
// - blending: no stop, plan from present speed
// - no blending: finish, stop, then plan next
// - blending only for multiple position segments
// - blending forces inter-segment delay to zero
// - earlier segment's setting, blend at decel point
// - speed mode: field is unit, rpm or pps
// - 3-bit field picks acceleration time, not jump
// - 3-bit field picks deceleration time, not jump
// - 3-bit field picks run speed, position only
// - 3-bit field picks delay time, not jump
// - pulse count index is base plus four n
// - target speed index is base plus four n
// - speed unit from control word top bit
// - interrupt switches now, carries remaining distance
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spfd_map.svh"

module spfd_top (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp,
	input  wire logic                  plan_decel_point,
	input  wire logic                  plan_seg_done,
	input  wire logic                  plan_delay_done,
	output logic                       seg_start,
	output logic                       carry_remainder,
	output logic                       blend_active,
	output logic                       stop_at_zero,
	output spfd_pkg::spfd_sel_type     seg_sel,
	output logic [5:0]                 seg_num,
	output logic [31:0]                seg0_value
);
	import spfd_pkg::*;

	// ----------------------------------------------------------------
	// Bus port
	// ----------------------------------------------------------------

	spfd_wreq_type wreq;
	logic [31:0]   rd_word;

	spfd_ahb_port u_port (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.rd_word   (rd_word),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wreq      (wreq)
	);

	// Address match, shared by write strobes and read mux
	function automatic logic addr_is(input logic [15:0] a, input logic [15:0] r);
		return a == r;
	endfunction

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------

	logic [31:0] ctrl_word;
	logic [31:0] next_word;
	logic [5:0]  start_seg;
	logic [5:0]  next_seg;
	logic [31:0] next_ctrl_word;
	logic [31:0] next_next_word;
	logic [31:0] next_seg0_value;
	logic [5:0]  next_start_seg;
	logic [5:0]  next_next_seg;

	// Write strobes in the data phase
	wire wr_ctrl;
	wire wr_next;
	wire wr_pulse;
	wire wr_seg;
	wire wr_cmd;
	wire start_cmd;
	wire trig_cmd;
	assign wr_ctrl   = wreq.en && addr_is(wreq.addr, `SPFD_A_CTRL);
	assign wr_next   = wreq.en && addr_is(wreq.addr, `SPFD_A_NEXT);
	assign wr_pulse  = wreq.en && addr_is(wreq.addr, `SPFD_A_PULSE);
	assign wr_seg    = wreq.en && addr_is(wreq.addr, `SPFD_A_SEG);
	assign wr_cmd    = wreq.en && addr_is(wreq.addr, `SPFD_A_CMD);
	assign start_cmd = wr_cmd && hwdata[`SPFD_C_START];
	assign trig_cmd  = wr_cmd && hwdata[`SPFD_C_TRIG];

	// Next register values; the read mux sees them so a read right after a write is fresh
	assign next_ctrl_word  = wr_ctrl ? hwdata : ctrl_word;
	assign next_next_word  = wr_next ? hwdata : next_word;
	assign next_seg0_value = wr_pulse ? hwdata : seg0_value;
	assign next_start_seg  = wr_seg ? hwdata[5:0] : start_seg;
	assign next_next_seg   = wr_seg ? hwdata[13:8] : next_seg;

	// Register storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_word  <= `SPFD_CTRL_RST;
			next_word  <= `SPFD_CTRL_RST;
			seg0_value <= `SPFD_PULSE_RST;
			start_seg  <= `SPFD_SEG_RST;
			next_seg   <= `SPFD_SEG_RST;
		end else begin
			ctrl_word  <= next_ctrl_word;
			next_word  <= next_next_word;
			seg0_value <= next_seg0_value;
			start_seg  <= next_start_seg;
			next_seg   <= next_next_seg;
		end
	end

	// ----------------------------------------------------------------
	// Field decode of the first and the following segment
	// ----------------------------------------------------------------

	spfd_sel_type first_sel;
	spfd_sel_type follow_sel;

	spfd_field_decode u_dec_first (
		.word (ctrl_word),
		.seg  (start_seg),
		.sel  (first_sel)
	);

	spfd_field_decode u_dec_follow (
		.word (next_word),
		.seg  (next_seg),
		.sel  (follow_sel)
	);

	// ----------------------------------------------------------------
	// Segment sequencer
	// ----------------------------------------------------------------

	spfd_state_type state;
	spfd_state_type next_state;
	spfd_sel_type   next_seg_sel;
	logic [5:0]     next_seg_num;
	logic           trig_pend;
	logic           next_trig_pend;

	// State classes and continuation
	wire in_idle;
	wire in_run;
	wire in_dly;
	wire cont;
	assign in_idle = (state == SPFD_ST_IDLE);
	assign in_run  = (state == SPFD_ST_RUN);
	assign in_dly  = (state == SPFD_ST_DELAY);
	assign cont    = (seg_sel.mode == SPFD_M_MULTI) || trig_pend;

	// Switch causes, interrupt first
	wire load_first;
	wire do_int;
	wire do_jump;
	wire do_blend;
	wire done_go;
	wire done_stop;
	wire delay_go;
	wire sw;
	assign load_first = in_idle && start_cmd;
	assign do_int     = (in_run || in_dly) && trig_cmd && follow_sel.intr;
	assign do_jump    = in_run && (seg_sel.mode == SPFD_M_JUMP);
	assign do_blend   = in_run && plan_decel_point && seg_sel.blend_en && cont;
	assign done_go    = in_run && plan_seg_done && cont;
	assign done_stop  = in_run && plan_seg_done && !cont;
	assign delay_go   = in_dly && plan_delay_done;
	assign sw         = do_int || do_jump || do_blend || (done_go && seg_sel.delay_zero)
		|| delay_go;

	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			SPFD_ST_IDLE: begin
				if (load_first) begin
					next_state = SPFD_ST_RUN;
				end
			end
			SPFD_ST_RUN: begin
				if (sw) begin
					next_state = SPFD_ST_RUN;
				end else if (done_go) begin
					next_state = SPFD_ST_DELAY;
				end else if (done_stop) begin
					next_state = SPFD_ST_IDLE;
				end
			end
			SPFD_ST_DELAY: begin
				if (sw) begin
					next_state = SPFD_ST_RUN;
				end
			end
			default: begin
				next_state = SPFD_ST_IDLE;
			end
		endcase
	end

	// Selection taken on a segment switch
	assign next_seg_sel = load_first ? first_sel : (sw ? follow_sel : seg_sel);
	assign next_seg_num = load_first ? start_seg : (sw ? next_seg : seg_num);

	// Pending trigger: a new trigger wins over the clear by a switch
	assign next_trig_pend = (trig_cmd && !do_int && !in_idle)
		|| (trig_pend && !sw && (next_state != SPFD_ST_IDLE));

	// Sequencer registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state           <= SPFD_ST_IDLE;
			seg_sel         <= '0;
			seg_num         <= 6'h00;
			trig_pend       <= 1'b0;
			seg_start       <= 1'b0;
			carry_remainder <= 1'b0;
		end else begin
			state           <= next_state;
			seg_sel         <= next_seg_sel;
			seg_num         <= next_seg_num;
			trig_pend       <= next_trig_pend;
			seg_start       <= load_first || sw;
			carry_remainder <= do_int;
		end
	end

	// Speed profile levels for the planner
	assign blend_active = in_run && seg_sel.blend_en;
	assign stop_at_zero = in_run && !seg_sel.blend_en;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------

	wire [15:0] ra;
	wire [31:0] status_word;
	assign ra          = haddr[15:0];
	assign status_word = {18'h00000, seg_num, 4'h0, blend_active, trig_pend, state};
	assign rd_word =
		addr_is(ra, `SPFD_A_CTRL)   ? next_ctrl_word :
		addr_is(ra, `SPFD_A_NEXT)   ? next_next_word :
		addr_is(ra, `SPFD_A_PULSE)  ? next_seg0_value :
		addr_is(ra, `SPFD_A_SEG)    ? {18'h00000, next_next_seg, 2'b00, next_start_seg} :
		addr_is(ra, `SPFD_A_STATUS) ? status_word : 32'h00000000;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	int_switch_a: assert property (do_int |=> seg_start && carry_remainder)
		else $error("interrupt trigger did not switch with carry");
	int_judge_a: assert property (in_run && trig_cmd && !follow_sel.intr && !sw
		|=> !seg_start && trig_pend)
		else $error("trigger without interrupt switched at once");
	blend_mode_a: assert property (seg_sel.blend_en |-> seg_sel.mode == SPFD_M_MULTI)
		else $error("blending outside multiple position mode");
	blend_switch_a: assert property (in_run && plan_decel_point && seg_sel.blend_en
		&& seg_sel.mode == SPFD_M_MULTI |=> seg_start && in_run)
		else $error("blend did not start next segment at decel");
	stop_wait_a: assert property (in_run && plan_seg_done && cont && !seg_sel.blend_en
		&& !do_int && !do_jump |=> in_dly && !seg_start ##1 (seg_start || in_dly))
		else $error("unblended segment did not wait in delay");
	delay_zero_a: assert property (seg_sel.blend_en |-> seg_sel.delay_zero && !stop_at_zero)
		else $error("blend kept a delay or a stop");
	unit_a: assert property (first_sel.unit_pps |-> first_sel.mode == SPFD_M_SPEED
		&& ctrl_word[31])
		else $error("speed unit flag not from word top bit");
	ramp_a: assert property (first_sel.mode == SPFD_M_SPEED |-> first_sel.accel_idx
		== `SPFD_RAMP_FIRST + {9'h000, ctrl_word[14:12]} && !first_sel.speed_valid)
		else $error("acceleration select wrong in speed mode");
	decel_a: assert property (first_sel.ramp_valid |-> first_sel.decel_idx <= `SPFD_RAMP_LAST
		&& first_sel.delay_idx <= `SPFD_DELAY_LAST)
		else $error("ramp or delay index out of its bank");
	ref_a: assert property (seg_start && seg_sel.mode == SPFD_M_SINGLE
		|-> seg_sel.ref_idx == `SPFD_PULSE_IDX + {4'h0, seg_num, 2'b00})
		else $error("pulse count index wrong");
	jump_a: assert property (in_run && seg_sel.mode == SPFD_M_JUMP
		|-> !seg_sel.ramp_valid && !seg_sel.speed_valid ##1 seg_start)
		else $error("jump segment did not jump at once");

	blend_c: cover property (do_blend ##1 seg_start);
	int_c: cover property (do_int ##1 carry_remainder);
	delay_c: cover property (in_dly ##1 delay_go ##1 seg_start);

endmodule
`default_nettype wire

// ### verilog/spfd_map.svh
// Offsets, field positions and reset values of the segment field decoder
`ifndef SPFD_MAP_SVH
`define SPFD_MAP_SVH

// ----------------------------------------------------------------
// Parameter indices of the drive
// ----------------------------------------------------------------
`define SPFD_CTRL_IDX    12'h804
`define SPFD_PULSE_IDX   12'h806
`define SPFD_RAMP_FIRST  12'h880
`define SPFD_RAMP_LAST   12'h887
`define SPFD_SPEED_FIRST 12'h888
`define SPFD_DELAY_FIRST 12'h890
`define SPFD_DELAY_LAST  12'h897

// ----------------------------------------------------------------
// Byte addresses on the register bus
// ----------------------------------------------------------------
`define SPFD_A_CTRL   16'h2010
`define SPFD_A_PULSE  16'h2018
`define SPFD_A_NEXT   16'h3000
`define SPFD_A_CMD    16'h3004
`define SPFD_A_SEG    16'h3008
`define SPFD_A_STATUS 16'h300C

// ----------------------------------------------------------------
// Control word fields (least significant bit of each)
// ----------------------------------------------------------------
`define SPFD_F_MODE 0
`define SPFD_F_INT  8
`define SPFD_F_ACC  12
`define SPFD_F_DEC  16
`define SPFD_F_SPD  20
`define SPFD_F_DLY  24
`define SPFD_F_OVL  31

// Command register bits
`define SPFD_C_START 0
`define SPFD_C_TRIG  1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPFD_CTRL_RST  32'h00000000
`define SPFD_PULSE_RST 32'h00000000
`define SPFD_SEG_RST   6'h00

`endif

// ### verilog/spfd_pkg.sv
// Types shared by the segment field decoder files
`default_nettype none

package spfd_pkg;

	// Sequencer states
	typedef enum logic [1:0] {
		SPFD_ST_IDLE  = 2'b00,
		SPFD_ST_RUN   = 2'b01,
		SPFD_ST_DELAY = 2'b10
	} spfd_state_type;

	// Segment modes held in the low field of a control word
	typedef enum logic [3:0] {
		SPFD_M_SINGLE = 4'h0,
		SPFD_M_MULTI  = 4'h1,
		SPFD_M_SPEED  = 4'h2,
		SPFD_M_JUMP   = 4'h3
	} spfd_mode_type;

	// Decoded segment selection handed to the planner
	typedef struct packed {
		spfd_mode_type mode;
		logic          intr;
		logic          blend_en;
		logic          unit_pps;
		logic          delay_zero;
		logic          ramp_valid;
		logic          speed_valid;
		logic [11:0]   accel_idx;
		logic [11:0]   decel_idx;
		logic [11:0]   speed_idx;
		logic [11:0]   delay_idx;
		logic [11:0]   ref_idx;
	} spfd_sel_type;

	// Write request carried from the bus port into the data phase
	typedef struct packed {
		logic        en;
		logic [15:0] addr;
	} spfd_wreq_type;

endpackage

`default_nettype wire

// ### verilog/spfd_field_decode.sv
// Decoder of one segment control word into parameter selections
`timescale 1ns/1ps
`default_nettype none
`include "spfd_map.svh"

module spfd_field_decode (
	input  wire logic [31:0]          word,
	input  wire logic [5:0]           seg,
	output spfd_pkg::spfd_sel_type    sel
);
	import spfd_pkg::*;

	// Mode classes
	spfd_mode_type mode;
	wire           pos;
	wire           spd;
	wire           ramp_ok;
	wire [11:0]    seg_x4;
	assign mode    = spfd_mode_type'(word[`SPFD_F_MODE +: 4]);
	assign pos     = (mode == SPFD_M_SINGLE) || (mode == SPFD_M_MULTI);
	assign spd     = (mode == SPFD_M_SPEED);
	assign ramp_ok = pos || spd;
	assign seg_x4  = {4'h0, seg, 2'b00};

	// Field decode; jump mode leaves every index at zero
	assign sel.mode        = mode;
	assign sel.intr        = word[`SPFD_F_INT];
	assign sel.blend_en    = (mode == SPFD_M_MULTI) && word[`SPFD_F_OVL];
	assign sel.unit_pps    = spd && word[`SPFD_F_OVL];
	assign sel.delay_zero  = sel.blend_en;
	assign sel.ramp_valid  = ramp_ok;
	assign sel.speed_valid = pos;
	assign sel.accel_idx   = ramp_ok ? `SPFD_RAMP_FIRST + {9'h000, word[`SPFD_F_ACC +: 3]}
		: 12'h000;
	assign sel.decel_idx   = ramp_ok ? `SPFD_RAMP_FIRST + {9'h000, word[`SPFD_F_DEC +: 3]}
		: 12'h000;
	assign sel.speed_idx   = pos ? `SPFD_SPEED_FIRST + {9'h000, word[`SPFD_F_SPD +: 3]}
		: 12'h000;
	assign sel.delay_idx   = ramp_ok ? `SPFD_DELAY_FIRST + {9'h000, word[`SPFD_F_DLY +: 3]}
		: 12'h000;
	assign sel.ref_idx     = pos ? `SPFD_PULSE_IDX + seg_x4
		: spd ? `SPFD_CTRL_IDX + seg_x4 : 12'h000;

endmodule
`default_nettype wire

// ### verilog/spfd_ahb_port.sv
// AHB-Lite slave port: address phase capture and read data register
`timescale 1ns/1ps
`default_nettype none

module spfd_ahb_port (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hready,
	input  wire logic [31:0]           rd_word,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	output spfd_pkg::spfd_wreq_type    wreq
);
	import spfd_pkg::*;

	// Address phase qualification; upper address bits must be zero
	wire take;
	wire hit;
	wire word_sz;
	assign take    = hsel && hready && htrans[1];
	assign hit     = (haddr[31:16] == 16'h0000);
	assign word_sz = (hsize == 3'h2);

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Capture write request and read data at the address phase edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wreq   <= '0;
			hrdata <= 32'h00000000;
		end else begin
			wreq.en   <= take && hwrite && hit && word_sz;
			wreq.addr <= haddr[15:0];
			hrdata    <= (take && !hwrite && hit) ? rd_word : 32'h00000000;
		end
	end

endmodule
`default_nettype wire

// ### sim/spfd_planner_model.sv
// Behavioural motion planner that answers the sequencer with timed pulses
`timescale 1ns/1ps
`default_nettype none

module spfd_planner_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       seg_start,
	input  wire logic       stop_at_zero,
	input  wire logic       run,
	input  wire logic [3:0] lat,
	output logic            plan_decel_point,
	output logic            plan_seg_done,
	output logic            plan_delay_done
);
	logic [7:0] cnt;

	// Cycles since the segment began, saturating so a stalled segment stays quiet
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 8'h00;
		end else if (seg_start) begin
			cnt <= 8'h01;
		end else if (cnt != 8'h00 && cnt != 8'hFF) begin
			cnt <= cnt + 8'h01;
		end
	end

	// Pulses; stopping only reported while the segment is meant to stop
	assign plan_decel_point = run && cnt == {4'h0, lat};
	assign plan_seg_done    = run && stop_at_zero && cnt == {4'h0, lat} + 8'h02;
	assign plan_delay_done  = run && cnt == {4'h0, lat} + 8'h10;
endmodule

`default_nettype wire

// ### sim/spfd_top_test.sv
// Testbench of the segment field decoder: bus tasks and sequencer tests
`timescale 1ns/1ps
`default_nettype none
`include "spfd_map.svh"

module spfd_top_test;
	import spfd_pkg::*;
	localparam int LIMIT = 6000;
	logic         hclk = 1'b0;
	logic         hresetn = 1'b0;
	logic         hsel = 1'b0;
	logic [31:0]  haddr = 32'h0;
	logic [1:0]   htrans = 2'b00;
	logic         hwrite = 1'b0;
	logic [2:0]   hsize = 3'h2;
	logic [31:0]  hwdata = 32'h0;
	logic         hreadyout;
	logic [31:0]  hrdata;
	logic         hresp;
	logic         dec_pt;
	logic         seg_done;
	logic         dly_done;
	logic         seg_start;
	logic         carry_remainder;
	logic         blend_active;
	logic         stop_at_zero;
	spfd_sel_type seg_sel;
	logic [5:0]   seg_num;
	logic [31:0]  seg0_value;
	logic         run = 1'b0;
	logic [3:0]   lat = 4'h4;
	int           cyc = 0;
	int           fails = 0;
	int           n_compared = 0;

	always #25 hclk = ~hclk;

	spfd_top i_spfd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.plan_decel_point(dec_pt), .plan_seg_done(seg_done), .plan_delay_done(dly_done),
		.seg_start(seg_start), .carry_remainder(carry_remainder),
		.blend_active(blend_active), .stop_at_zero(stop_at_zero), .seg_sel(seg_sel),
		.seg_num(seg_num), .seg0_value(seg0_value));

	spfd_planner_model i_spfd_planner_model (.hclk(hclk), .hresetn(hresetn),
		.seg_start(seg_start), .stop_at_zero(stop_at_zero), .run(run), .lat(lat),
		.plan_decel_point(dec_pt), .plan_seg_done(seg_done), .plan_delay_done(dly_done));

	// Verdict and end of run
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cycle count and hang guard
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			conclude();
		end
	end

	task automatic chk(input string name, input logic [71:0] e, input logic [71:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", name, e, g);
		end
	endtask

	// One AHB-Lite single transfer of size sz, read data taken at the closing edge
	task automatic xfer(input logic [31:0] a, input logic wr, input logic [2:0] sz,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			rd = hrdata;
		end while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] v;
		xfer(a, 1'b1, 3'h2, d, v);
	endtask

	task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] v;
		xfer(a, 1'b0, 3'h2, 32'h0, v);
		chk(name, e, v);
		chk("hresp", 1'b0, hresp);
	endtask

	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	// Bounded wait for a segment start, sampled between edges
	task automatic wait_start(output int t, output logic ok);
		ok = 1'b0;
		t = 0;
		for (int i = 0; i < 60; i++) begin
			@(negedge hclk);
			if (seg_start === 1'b1) begin
				t = cyc;
				ok = 1'b1;
				return;
			end
		end
	endtask

	task automatic start(input logic [31:0] c, input logic [31:0] nx, input logic [31:0] sg,
		output int t);
		logic ok;
		do_reset();
		wr(`SPFD_A_CTRL, c);
		wr(`SPFD_A_NEXT, nx);
		wr(`SPFD_A_SEG, sg);
		wr(`SPFD_A_CMD, 32'h1);
		wait_start(t, ok);
		chk("seg_start", 1'b1, ok);
	endtask

	// Selection expected from a control word and segment number
	function automatic spfd_sel_type exp_sel(input logic [31:0] w, input logic [5:0] n);
		spfd_sel_type s;
		logic pos;
		logic ramp;
		s = '0;
		pos = w[3:0] == 4'h0 || w[3:0] == 4'h1;
		ramp = pos || w[3:0] == 4'h2;
		s.mode = spfd_mode_type'(w[3:0]);
		s.intr = w[8];
		s.blend_en = w[3:0] == 4'h1 && w[31];
		s.unit_pps = w[3:0] == 4'h2 && w[31];
		s.delay_zero = s.blend_en;
		s.ramp_valid = ramp;
		s.speed_valid = pos;
		if (ramp) begin
			s.accel_idx = `SPFD_RAMP_FIRST + {9'h0, w[14:12]};
			s.decel_idx = `SPFD_RAMP_FIRST + {9'h0, w[18:16]};
			s.delay_idx = `SPFD_DELAY_FIRST + {9'h0, w[26:24]};
		end
		if (pos) begin
			s.speed_idx = `SPFD_SPEED_FIRST + {9'h0, w[22:20]};
			s.ref_idx = `SPFD_PULSE_IDX + {4'h0, n, 2'b00};
		end
		if (w[3:0] == 4'h2) begin
			s.ref_idx = `SPFD_CTRL_IDX + {4'h0, n, 2'b00};
		end
		return s;
	endfunction

	initial begin
		int t0;
		int t1;
		logic ok;
		logic [31:0] w;
		logic [5:0] n;
		spfd_sel_type e;
		spfd_sel_type g;
		do_reset();
		// Register reset values, refusals and read-back
		rdchk("ctrl", `SPFD_A_CTRL, `SPFD_CTRL_RST);
		rdchk("pulse", `SPFD_A_PULSE, `SPFD_PULSE_RST);
		rdchk("seg", `SPFD_A_SEG, 32'h0);
		rdchk("status", `SPFD_A_STATUS, 32'h0);
		wr(`SPFD_A_PULSE, 32'h80000001);
		rdchk("pulse", `SPFD_A_PULSE, 32'h80000001);
		chk("seg0_value", 32'h80000001, seg0_value);
		wr(32'h00012018, 32'h5);
		xfer(`SPFD_A_PULSE, 1'b1, 3'h1, 32'h7, w);
		rdchk("pulse", `SPFD_A_PULSE, 32'h80000001);
		rdchk("unmapped", 32'h00012018, 32'h0);
		rdchk("cmd", `SPFD_A_CMD, 32'h0);
		$display("test registers done");
		// Every mode with every selector value and boundary segment numbers
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 8; k++) begin
				n = 6'(k * 9);
				w = {k[0], 4'h0, 3'(k + 3), 1'b0, 3'(k + 2), 1'b0, 3'(k + 1), 1'b0, 3'(k),
					3'h0, k[1], 4'h0, 4'(m)};
				start(w, 32'h0, {26'h0, n}, t0);
				e = exp_sel(w, n);
				g = seg_sel;
				if (m == 3) begin
					e.delay_zero = 1'b0;
					g.delay_zero = 1'b0;
				end
				chk("seg_sel", 72'(e), 72'(g));
				chk("accel_idx", e.accel_idx, g.accel_idx);
				chk("decel_idx", e.decel_idx, g.decel_idx);
				chk("speed_idx", e.speed_idx, g.speed_idx);
				chk("delay_idx", e.delay_idx, g.delay_idx);
				chk("ref_idx", e.ref_idx, g.ref_idx);
				chk("seg_num", n, seg_num);
			end
		end
		$display("test decode done");
		// Blending multi segment switches at the decel point with no delay
		run <= 1'b1;
		lat <= 4'h9;
		start(32'h80000001, 32'h0, 32'h0301, t0);
		rdchk("status", `SPFD_A_STATUS, 32'h0109);
		wait_start(t1, ok);
		chk("blend gap", 10, t1 - t0);
		chk("seg_num", 6'h3, seg_num);
		$display("test blend done");
		// No blending: stop, delay, then next segment
		lat <= 4'h4;
		start(32'h05000001, 32'h0, 32'h0401, t0);
		repeat (7) @(posedge hclk);
		rdchk("status", `SPFD_A_STATUS, 32'h0102);
		wait_start(t1, ok);
		chk("stop gap", 21, t1 - t0);
		chk("seg_num", 6'h4, seg_num);
		$display("test stop done");
		// Overlap bit on a single segment is ignored
		start(32'h80000000, 32'h0, 32'h0501, t0);
		@(negedge hclk);
		chk("blend_active", 1'b0, blend_active);
		chk("stop_at_zero", 1'b1, stop_at_zero);
		wait_start(t1, ok);
		chk("seg_start", 1'b0, ok);
		$display("test single done");
		// Interrupting trigger switches at once with carry
		run <= 1'b0;
		start(32'h00000001, 32'h80000102, 32'h0902, t0);
		wr(`SPFD_A_CMD, 32'h2);
		wait_start(t1, ok);
		chk("seg_start", 1'b1, ok);
		chk("carry", 1'b1, carry_remainder);
		chk("seg_num", 6'h9, seg_num);
		chk("seg_sel", 72'(exp_sel(32'h80000102, 6'h9)), 72'(seg_sel));
		$display("test interrupt done");
		// Interrupt bit of the earlier segment has no effect on the trigger
		run <= 1'b1;
		lat <= 4'h9;
		start(32'h00000100, 32'h0, 32'h0C01, t0);
		wr(`SPFD_A_CMD, 32'h2);
		wait_start(t1, ok);
		chk("pending gap", 26, t1 - t0);
		chk("carry", 1'b0, carry_remainder);
		chk("seg_num", 6'hC, seg_num);
		$display("test pending done");
		conclude();
	end
endmodule

`default_nettype wire
